// [rtl/isa_top.sv]
// Purpose: Sequence input allocation for seven connector pins
// Assumes: AXI4-Lite slave on aclk; pins asynchronous to aclk
// Notes: Fixed or free allocation chosen by the allocation-mode digit
// Notes on behaviour
// - Method change remaps pins in fixed mode, keeps stored maps
// - Method 3: pins 41,45,46 direction, speeds
// - Pins 40,42,43,44 fixed in fixed mode
// - Methods 0-2 proportional, force limits; 3-6 speeds
// - Methods 7-9: pin 41 method switch
// - Method A zero hold, B pulse inhibit
// - Free mode only when allocation digit is 1
// - Digits 0-6 pins, 9-F inverted pins
// - Digit 7 always on, 8 always off
// - Shared pin drives every selecting function
// - Polarity per function as listed
// - Digit positions in the two map registers
`timescale 1ns/100ps
`default_nettype none
module isa_top import isa_pkg::*; (
  input wire logic aclk, // Clock, 125 MHz
  input wire logic aresetn, // Sync reset, active low
  input wire logic [7:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write byte enables
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [7:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  input wire logic [6:0] seq_pin, // Connector pins 40..46, bit 0 = 40
  output logic servo_on, // Servo on
  output logic proportional_op_in, // Proportional operation
  output logic forward_travel_block_in, // Forward travel prohibit
  output logic reverse_travel_block_in, // Reverse travel prohibit
  output logic fault_clear_in, // Alarm reset
  output logic forward_force_limit_in, // Forward force limit
  output logic reverse_force_limit_in, // Reverse force limit
  output logic move_direction_select_in, // Direction select
  output logic preset_speed_select_a, // Preset speed select A
  output logic preset_speed_select_b, // Preset speed select B
  output logic method_switch_in, // Control method switch
  output logic zero_hold_in, // Zero clamp
  output logic pulse_inhibit_in // Reference pulse inhibit
);
  logic [15:0] control_method_select_r;
  logic [15:0] input_map_first_r;
  logic [15:0] input_map_second_r;
  logic [6:0] pin_meta_r;
  logic [6:0] pin_sync_r;
  logic aw_held_r;
  logic [7:0] aw_addr_r;
  logic w_held_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  logic do_write;
  logic [3:0] method;
  logic free_mode;
  isa_role_e pin41_role;
  logic [3:0] digit_eff [ISA_NUM_FUNC];
  wire [12:0] func_vec;
  logic [31:0] status_word;

  // Merge byte lanes into a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] data,
                                          input logic [3:0] strb);
    logic [15:0] res;
    res = old;
    if (strb[0]) begin
      res[7:0] = data[7:0];
    end
    if (strb[1]) begin
      res[15:8] = data[15:8];
    end
    return res;
  endfunction

  // Pick a four-bit digit out of a register
  function automatic logic [3:0] digit_of(input logic [15:0] word, input int lsb);
    return 4'((word >> lsb) & 16'h000f);
  endfunction

  // Role of pin 41 for a control method code
  function automatic isa_role_e role_of(input logic [3:0] code);
    isa_role_e r;
    r = ISA_ROLE_PROP;
    if (code >= ISA_METH_PRESET && code <= ISA_METH_PRESET_LAST) begin
      r = ISA_ROLE_DIR;
    end else if (code > ISA_METH_PRESET_LAST && code <= ISA_METH_SWITCH_LAST) begin
      r = ISA_ROLE_CSW;
    end else if (code == ISA_METH_ZERO_HOLD) begin
      r = ISA_ROLE_ZERO;
    end else if (code == ISA_METH_INHIBIT) begin
      r = ISA_ROLE_INH;
    end
    return r;
  endfunction

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_meta_r <= 7'h00;
      pin_sync_r <= 7'h00;
    end else begin
      pin_meta_r <= seq_pin;
      pin_sync_r <= pin_meta_r;
    end
  end

  // Write address and data capture, either order
  assign s_axi_awready = !aw_held_r && !bvalid_r;
  assign s_axi_wready = !w_held_r && !bvalid_r;
  assign do_write = aw_held_r && w_held_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_held_r <= 1'b0;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end else if (do_write) begin
        aw_held_r <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end else if (do_write) begin
        w_held_r <= 1'b0;
      end
    end
  end

  // Write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r <= ISA_RESP_OKAY;
    end else if (do_write) begin
      bvalid_r <= 1'b1;
      bresp_r <= (aw_addr_r[7:2] <= ISA_OFF_STATUS[7:2]) ? ISA_RESP_OKAY : ISA_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;

  // stored parameters; method write leaves maps alone
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      control_method_select_r <= ISA_RST_METHOD;
      input_map_first_r <= ISA_RST_MAP1;
      input_map_second_r <= ISA_RST_MAP2;
    end else if (do_write) begin
      unique case (aw_addr_r[7:2])
        ISA_OFF_METHOD[7:2]: begin
          control_method_select_r <= merge16(control_method_select_r, w_data_r, w_strb_r);
        end
        ISA_OFF_MAP1[7:2]: begin
          input_map_first_r <= merge16(input_map_first_r, w_data_r, w_strb_r);
        end
        ISA_OFF_MAP2[7:2]: begin
          input_map_second_r <= merge16(input_map_second_r, w_data_r, w_strb_r);
        end
        default: begin
        end
      endcase
    end
  end

  // Status word: functions, pins, mode
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[12:0] = func_vec;
    status_word[ISA_ST_PINS_LSB +: 7] = pin_sync_r;
    status_word[ISA_ST_FREE_BIT] = free_mode;
  end

  // Read channel, one outstanding read
  assign s_axi_arready = !rvalid_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= ISA_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_r <= 1'b1;
      rresp_r <= ISA_RESP_OKAY;
      unique case (s_axi_araddr[7:2])
        ISA_OFF_METHOD[7:2]: rdata_r <= {16'h0000, control_method_select_r};
        ISA_OFF_MAP1[7:2]: rdata_r <= {16'h0000, input_map_first_r};
        ISA_OFF_MAP2[7:2]: rdata_r <= {16'h0000, input_map_second_r};
        ISA_OFF_STATUS[7:2]: rdata_r <= status_word;
        default: begin
          rdata_r <= 32'h0000_0000;
          rresp_r <= ISA_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

  assign method = digit_of(control_method_select_r, ISA_METHOD_LSB);
  assign free_mode = digit_of(input_map_first_r, ISA_ALLOC_LSB) == ISA_ALLOC_FREE;
  assign pin41_role = role_of(method);

  // Effective digit per function
  always_comb begin
    for (int i = 0; i < ISA_NUM_FUNC; i++) begin
      digit_eff[i] = ISA_DIG_OFF;
    end
    if (free_mode) begin
      digit_eff[ISA_F_SERVO] = digit_of(input_map_first_r, ISA_SERVO_LSB);
      digit_eff[ISA_F_PROP] = digit_of(input_map_first_r, ISA_PROP_LSB);
      digit_eff[ISA_F_FWDB] = digit_of(input_map_first_r, ISA_FWDB_LSB);
      digit_eff[ISA_F_REVB] = digit_of(input_map_second_r, ISA_REVB_LSB);
      digit_eff[ISA_F_FAULT] = digit_of(input_map_second_r, ISA_FAULT_LSB);
      digit_eff[ISA_F_FWDF] = digit_of(input_map_second_r, ISA_FWDF_LSB);
    end else begin
      // fixed pins 40, 42, 43, 44
      digit_eff[ISA_F_SERVO] = ISA_PIN40;
      digit_eff[ISA_F_FWDB] = ISA_PIN42;
      digit_eff[ISA_F_REVB] = ISA_PIN43;
      digit_eff[ISA_F_FAULT] = ISA_PIN44;
      if (pin41_role == ISA_ROLE_DIR) begin
        digit_eff[ISA_F_SPDA] = ISA_PIN45;
        digit_eff[ISA_F_SPDB] = ISA_PIN46;
      end else begin
        digit_eff[ISA_F_FWDF] = ISA_PIN45;
        digit_eff[ISA_F_REVF] = ISA_PIN46;
      end
      unique case (pin41_role)
        ISA_ROLE_PROP: digit_eff[ISA_F_PROP] = ISA_PIN41;
        ISA_ROLE_DIR: digit_eff[ISA_F_DIR] = ISA_PIN41;
        ISA_ROLE_CSW: digit_eff[ISA_F_CSW] = ISA_PIN41;
        ISA_ROLE_ZERO: digit_eff[ISA_F_ZERO] = ISA_PIN41;
        ISA_ROLE_INH: digit_eff[ISA_F_INH] = ISA_PIN41;
      endcase
    end
  end

  // one resolver per function, shared pins
  for (genvar g = 0; g < ISA_NUM_FUNC; g++) begin : g_func
    isa_func_resolve #(
      .FIRST_LOW(ISA_FIRST_LOW[g])
    ) u_res (
      .aclk(aclk),
      .aresetn(aresetn),
      .digit(digit_eff[g]),
      .pins(pin_sync_r),
      .asserted(func_vec[g])
    );
  end

  // Function outputs
  assign servo_on = func_vec[ISA_F_SERVO];
  assign proportional_op_in = func_vec[ISA_F_PROP];
  assign forward_travel_block_in = func_vec[ISA_F_FWDB];
  assign reverse_travel_block_in = func_vec[ISA_F_REVB];
  assign fault_clear_in = func_vec[ISA_F_FAULT];
  assign forward_force_limit_in = func_vec[ISA_F_FWDF];
  assign reverse_force_limit_in = func_vec[ISA_F_REVF];
  assign move_direction_select_in = func_vec[ISA_F_DIR];
  assign preset_speed_select_a = func_vec[ISA_F_SPDA];
  assign preset_speed_select_b = func_vec[ISA_F_SPDB];
  assign method_switch_in = func_vec[ISA_F_CSW];
  assign zero_hold_in = func_vec[ISA_F_ZERO];
  assign pulse_inhibit_in = func_vec[ISA_F_INH];

  // Checks: helper marks one cycle out of reset
  logic live_r;
  logic [3:0] sv_dig;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      live_r <= 1'b0;
    end else begin
      live_r <= 1'b1;
    end
  end
  assign sv_dig = digit_of(input_map_first_r, ISA_SERVO_LSB);

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_fixed_safety;
    live_r && $past(!free_mode) |-> servo_on == !$past(pin_sync_r[0])
      && forward_travel_block_in == $past(pin_sync_r[2])
      && reverse_travel_block_in == $past(pin_sync_r[3])
      && fault_clear_in == !$past(pin_sync_r[4]);
  endproperty
  a_fixed_safety: assert property (p_fixed_safety) else $error("fixed pin 40-44 wrong");

  property p_preset;
    live_r && $past(!free_mode && method == ISA_METH_PRESET) |->
      move_direction_select_in == !$past(pin_sync_r[1])
      && preset_speed_select_a == !$past(pin_sync_r[5])
      && preset_speed_select_b == !$past(pin_sync_r[6]) && !forward_force_limit_in;
  endproperty
  a_preset: assert property (p_preset) else $error("method 3 remap wrong");

  property p_plain;
    live_r && $past(!free_mode && method <= ISA_METH_PLAIN_LAST) |->
      proportional_op_in == !$past(pin_sync_r[1])
      && forward_force_limit_in == !$past(pin_sync_r[5]) && !move_direction_select_in;
  endproperty
  a_plain: assert property (p_plain) else $error("methods 0-2 map wrong");

  property p_switch;
    live_r && $past(!free_mode && method > ISA_METH_PRESET_LAST
      && method <= ISA_METH_SWITCH_LAST) |->
      method_switch_in == !$past(pin_sync_r[1])
      && reverse_force_limit_in == !$past(pin_sync_r[6]) && !proportional_op_in;
  endproperty
  a_switch: assert property (p_switch) else $error("methods 7-9 map wrong");

  property p_zero_inh;
    live_r && $past(!free_mode && method == ISA_METH_ZERO_HOLD) |->
      zero_hold_in == !$past(pin_sync_r[1]) && !pulse_inhibit_in;
  endproperty
  a_zero_inh: assert property (p_zero_inh) else $error("method A map wrong");

  property p_free_only;
    live_r && $past(free_mode) |-> !move_direction_select_in && !zero_hold_in;
  endproperty
  a_free_only: assert property (p_free_only) else $error("fixed role in free mode");

  property p_forced;
    (live_r && $past(free_mode && sv_dig == ISA_DIG_ON) |-> servo_on)
      and (live_r && $past(free_mode && sv_dig == ISA_DIG_OFF) |-> !servo_on);
  endproperty
  a_forced: assert property (p_forced) else $error("forced digit ignored");

  property p_inverted;
    live_r && $past(free_mode && sv_dig >= ISA_DIG_INV_BASE) |->
      servo_on == $past(pin_sync_r[3'(sv_dig - ISA_DIG_INV_BASE)]);
  endproperty
  a_inverted: assert property (p_inverted) else $error("inverted pin wrong");

  property p_shared;
    live_r && $past(free_mode && sv_dig <= ISA_DIG_PIN_MAX
      && sv_dig == digit_of(input_map_first_r, ISA_FWDB_LSB)) |->
      servo_on != forward_travel_block_in;
  endproperty
  a_shared: assert property (p_shared) else $error("shared pin mismatch");

  property p_map_kept;
    do_write && aw_addr_r[7:2] == ISA_OFF_METHOD[7:2] |=> $stable(input_map_first_r)
      && $stable(input_map_second_r);
  endproperty
  a_map_kept: assert property (p_map_kept) else $error("method write hit map");

  c_free: cover property (live_r && free_mode && servo_on);
  c_preset: cover property (method == ISA_METH_PRESET && preset_speed_select_a);
  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_read: cover property (s_axi_rvalid && s_axi_rready);
endmodule
`default_nettype wire

// [rtl/isa_pkg.sv]
// Purpose: Shared constants for the input signal allocation block
// Assumes: 32-bit AXI4-Lite register window, 8-bit byte address
// Notes: Digit values follow the hex-digit allocation scheme
package isa_pkg;
  // Register byte offsets
  localparam logic [7:0] ISA_OFF_METHOD = 8'h00;
  localparam logic [7:0] ISA_OFF_MAP1 = 8'h04;
  localparam logic [7:0] ISA_OFF_MAP2 = 8'h08;
  localparam logic [7:0] ISA_OFF_STATUS = 8'h0c;
  // Reset values of the stored parameters
  localparam logic [15:0] ISA_RST_METHOD = 16'h0000;
  localparam logic [15:0] ISA_RST_MAP1 = 16'h2100;
  localparam logic [15:0] ISA_RST_MAP2 = 16'h6543;
  // Digit field positions
  localparam int ISA_METHOD_LSB = 4;
  localparam int ISA_ALLOC_LSB = 0;
  localparam int ISA_SERVO_LSB = 4;
  localparam int ISA_PROP_LSB = 8;
  localparam int ISA_FWDB_LSB = 12;
  localparam int ISA_REVB_LSB = 0;
  localparam int ISA_FAULT_LSB = 4;
  localparam int ISA_FWDF_LSB = 8;
  // Status register field positions
  localparam int ISA_ST_PINS_LSB = 16;
  localparam int ISA_ST_FREE_BIT = 24;
  // Digit values
  localparam logic [3:0] ISA_DIG_PIN_MAX = 4'h6;
  localparam logic [3:0] ISA_DIG_ON = 4'h7;
  localparam logic [3:0] ISA_DIG_OFF = 4'h8;
  localparam logic [3:0] ISA_DIG_INV_BASE = 4'h9;
  localparam logic [3:0] ISA_ALLOC_FREE = 4'h1;
  // Pin digits, pin 40 first
  localparam logic [3:0] ISA_PIN40 = 4'h0;
  localparam logic [3:0] ISA_PIN41 = 4'h1;
  localparam logic [3:0] ISA_PIN42 = 4'h2;
  localparam logic [3:0] ISA_PIN43 = 4'h3;
  localparam logic [3:0] ISA_PIN44 = 4'h4;
  localparam logic [3:0] ISA_PIN45 = 4'h5;
  localparam logic [3:0] ISA_PIN46 = 4'h6;
  // Control method codes
  localparam logic [3:0] ISA_METH_PLAIN_LAST = 4'h2;
  localparam logic [3:0] ISA_METH_PRESET = 4'h3;
  localparam logic [3:0] ISA_METH_PRESET_LAST = 4'h6;
  localparam logic [3:0] ISA_METH_SWITCH_LAST = 4'h9;
  localparam logic [3:0] ISA_METH_ZERO_HOLD = 4'ha;
  localparam logic [3:0] ISA_METH_INHIBIT = 4'hb;
  // Function indices and first-listed polarity (1 = active low)
  localparam int ISA_NUM_FUNC = 13;
  localparam int ISA_F_SERVO = 0;
  localparam int ISA_F_PROP = 1;
  localparam int ISA_F_FWDB = 2;
  localparam int ISA_F_REVB = 3;
  localparam int ISA_F_FAULT = 4;
  localparam int ISA_F_FWDF = 5;
  localparam int ISA_F_REVF = 6;
  localparam int ISA_F_DIR = 7;
  localparam int ISA_F_SPDA = 8;
  localparam int ISA_F_SPDB = 9;
  localparam int ISA_F_CSW = 10;
  localparam int ISA_F_ZERO = 11;
  localparam int ISA_F_INH = 12;
  localparam logic [12:0] ISA_FIRST_LOW = 13'h1ff3;
  // Bus responses
  localparam logic [1:0] ISA_RESP_OKAY = 2'b00;
  localparam logic [1:0] ISA_RESP_SLVERR = 2'b10;
  // Role of pin 41 in the fixed allocation
  typedef enum logic [2:0] {
    ISA_ROLE_PROP, ISA_ROLE_DIR, ISA_ROLE_CSW, ISA_ROLE_ZERO, ISA_ROLE_INH
  } isa_role_e;
endpackage

// [rtl/isa_func_resolve.sv]
// Purpose: Resolve one function's asserted state from its digit
// Assumes: Pins already synchronised to aclk
// Notes: Output is registered
`timescale 1ns/100ps
`default_nettype none
module isa_func_resolve import isa_pkg::*; #(
  parameter bit FIRST_LOW = 1'b1
) (
  input wire logic aclk, // Clock
  input wire logic aresetn, // Sync reset, active low
  input wire logic [3:0] digit, // Allocation digit
  input wire logic [6:0] pins, // Synchronised pin levels
  output logic asserted // Function asserted
);
  logic asserted_nxt;
  logic [3:0] inv_idx;

  // Pin select, polarity, forced states
  always_comb begin
    inv_idx = digit - ISA_DIG_INV_BASE;
    if (digit <= ISA_DIG_PIN_MAX) begin
      asserted_nxt = FIRST_LOW ? ~pins[digit[2:0]] : pins[digit[2:0]];
    end else if (digit == ISA_DIG_ON) begin
      asserted_nxt = 1'b1;
    end else if (digit == ISA_DIG_OFF) begin
      asserted_nxt = 1'b0;
    end else begin
      asserted_nxt = FIRST_LOW ? pins[inv_idx[2:0]] : ~pins[inv_idx[2:0]];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      asserted <= 1'b0;
    end else begin
      asserted <= asserted_nxt;
    end
  end
endmodule
`default_nettype wire

// [verification/isa_pin_switches.sv]
// Purpose: Switches wired to the seven sequence input pins
// Assumes: Levels change at any time relative to aclk
// Notes: Contact bounce is not modelled
`timescale 1ns/100ps
`default_nettype none
module isa_pin_switches (
  input wire logic [6:0] level_req, // Levels asked by the bench
  output logic [6:0] seq_pin // Pin levels, bit 0 = pin 40
);
  // All contacts open at power up
  initial seq_pin = 7'h7f;
  // default polarity wiring
  // Contact settles a few ns after the request, off the clock edge
  always @(level_req) seq_pin <= #3 level_req;
endmodule
`default_nettype wire

// [verification/input_signal_allocation_tb.sv]
// Purpose: Self-checking bench for the sequence input allocation block
// Assumes: AXI4-Lite master tasks, pins set through the switch model
// Notes: Outputs sampled at the falling edge, inputs driven at the rising edge
`timescale 1ns/100ps
`default_nettype none
module input_signal_allocation_tb;
  import isa_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = '0, araddr = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = '0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [6:0] pin_req = 7'h7f;
  logic [6:0] seq_pin;
  wire [12:0] fn;
  logic [3:0] wstrb = 4'hf;
  int err_total = 0;
  int checks = 0;

  // Clock, 8 ns period
  always #4 aclk = ~aclk;

  // Device under test
  isa_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .seq_pin(seq_pin), .servo_on(fn[0]),
    .proportional_op_in(fn[1]), .forward_travel_block_in(fn[2]),
    .reverse_travel_block_in(fn[3]), .fault_clear_in(fn[4]),
    .forward_force_limit_in(fn[5]), .reverse_force_limit_in(fn[6]),
    .move_direction_select_in(fn[7]), .preset_speed_select_a(fn[8]),
    .preset_speed_select_b(fn[9]), .method_switch_in(fn[10]),
    .zero_hold_in(fn[11]), .pulse_inhibit_in(fn[12]));

  // Far side switches
  isa_pin_switches sw (.level_req(pin_req), .seq_pin(seq_pin));

  // Compare helpers
  task automatic chk_fn(input logic [12:0] e);
    @(negedge aclk);
    checks++;
    if (fn !== e) begin
      err_total++;
      $display("unexpected at %0t: functions %h, wanted %h", $time, fn, e);
    end
  endtask

  task automatic chk_bus(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("unexpected at %0t: bus value %h, wanted %h", $time, g, e);
    end
  endtask

  // Bus write, one outstanding
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw, w, b;
    logic [1:0] r;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge aclk);
      aw = awvalid && awready;
      w = wvalid && wready;
      b = bvalid;
      r = bresp;
      @(posedge aclk);
      if (aw) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
    end while (!b);
    bready <= 1'b0;
    chk_bus({30'h0, r}, {30'h0, er});
  endtask

  // Bus read, one outstanding
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic ar, rv;
    logic [31:0] d;
    logic [1:0] r;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge aclk);
      ar = arvalid && arready;
      rv = rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ar) arvalid <= 1'b0;
    end while (!rv);
    rready <= 1'b0;
    chk_bus({30'h0, r}, {30'h0, er});
    chk_bus(d, ed);
  endtask

  // Pin change, then room for sync and resolve
  task automatic set_pins(input logic [6:0] p);
    @(posedge aclk);
    pin_req <= p;
    repeat (5) @(posedge aclk);
  endtask

  // Fixed allocation expectation
  function automatic logic [12:0] fx(input logic [3:0] m, input logic [6:0] p);
    logic [12:0] e;
    e = '0;
    e[0] = ~p[0];
    e[2] = p[2];
    e[3] = p[3];
    e[4] = ~p[4];
    if (m >= 4'h3 && m <= 4'h6) begin
      e[7] = ~p[1];
      e[8] = ~p[5];
      e[9] = ~p[6];
    end else begin
      e[5] = ~p[5];
      e[6] = ~p[6];
      if (m >= 4'h7 && m <= 4'h9) e[10] = ~p[1];
      else if (m == 4'ha) e[11] = ~p[1];
      else if (m == 4'hb) e[12] = ~p[1];
      else e[1] = ~p[1];
    end
    return e;
  endfunction

  // Free allocation of one function; lo set means active low
  function automatic logic fr(input logic [3:0] d, input logic lo, input logic [6:0] p);
    if (d == 4'h7) return 1'b1;
    if (d == 4'h8) return 1'b0;
    if (d <= 4'h6) return p[d[2:0]] ^ lo;
    return p[3'(d - 4'h9)] ^ ~lo;
  endfunction

  task automatic t_end(input string s);
    $display("test %s done, mismatches so far %0d", s, err_total);
  endtask

  task automatic wrap_up;
    $display("comparisons %0d, mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Hang guard
  initial begin
    #400000;
    err_total++;
    wrap_up;
  end

  // Test sequence
  initial begin
    logic [6:0] p;
    logic [3:0] dg [6];
    logic [12:0] ef;
    logic [6:0] pat [3];
    pat = '{7'h55, 7'h2a, 7'h00};
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(ISA_OFF_METHOD, 32'h0, ISA_RESP_OKAY);
    axi_rd(ISA_OFF_MAP1, 32'h2100, ISA_RESP_OKAY);
    axi_rd(ISA_OFF_MAP2, 32'h6543, ISA_RESP_OKAY);
    axi_rd(8'h10, 32'h0, ISA_RESP_SLVERR);
    axi_wr(8'h10, 32'h0000ffff, ISA_RESP_SLVERR);
    axi_wr(ISA_OFF_STATUS, 32'h0000ffff, ISA_RESP_OKAY);
    // Upper byte lane only, lower byte kept
    wstrb <= 4'h2;
    axi_wr(ISA_OFF_MAP2, 32'h00001234, ISA_RESP_OKAY);
    axi_rd(ISA_OFF_MAP2, 32'h1243, ISA_RESP_OKAY);
    wstrb <= 4'hf;
    axi_wr(ISA_OFF_MAP2, 32'h00006543, ISA_RESP_OKAY);
    axi_rd(ISA_OFF_MAP1, 32'h2100, ISA_RESP_OKAY);
    t_end("registers");
    // Every method, each pin low alone, then all low
    for (int m = 0; m < 16; m++) begin
      axi_wr(ISA_OFF_METHOD, {24'h0, 4'(m), 4'h0}, ISA_RESP_OKAY);
      for (int k = 0; k < 8; k++) begin
        p = (k == 7) ? 7'h00 : ~(7'h01 << k);
        set_pins(p);
        chk_fn(fx(4'(m), p));
      end
      axi_rd(ISA_OFF_MAP2, 32'h6543, ISA_RESP_OKAY);
    end
    t_end("fixed");
    // Free mode, digits spread so some functions share a pin
    for (int d = 0; d < 16; d++) begin
      for (int i = 0; i < 6; i++) dg[i] = 4'(d + 3 * i);
      axi_wr(ISA_OFF_MAP1, {16'h0, dg[2], dg[1], dg[0], 4'h1}, ISA_RESP_OKAY);
      axi_wr(ISA_OFF_MAP2, {16'h0, 4'h6, dg[5], dg[4], dg[3]}, ISA_RESP_OKAY);
      for (int j = 0; j < 3; j++) begin
        p = pat[j];
        ef = {7'h0, fr(dg[5], 1'b1, p), fr(dg[4], 1'b1, p), fr(dg[3], 1'b0, p),
          fr(dg[2], 1'b0, p), fr(dg[1], 1'b1, p), fr(dg[0], 1'b1, p)};
        set_pins(p);
        chk_fn(ef);
      end
    end
    axi_rd(ISA_OFF_STATUS, {7'h0, 1'b1, 1'b0, p, 3'h0, ef}, ISA_RESP_OKAY);
    // Servo on and forward prohibit on one pin, opposite polarity
    axi_wr(ISA_OFF_MAP2, 32'h00006543, ISA_RESP_OKAY);
    axi_wr(ISA_OFF_MAP1, 32'h00002321, ISA_RESP_OKAY);
    set_pins(7'h1a);
    chk_fn(13'h0029);
    // Allocation digit other than 1 falls back to fixed
    axi_wr(ISA_OFF_MAP1, 32'h00005552, ISA_RESP_OKAY);
    set_pins(7'h1a);
    chk_fn(fx(4'hf, 7'h1a));
    t_end("free");
    wrap_up;
  end
endmodule
`default_nettype wire
